// ### pkg/pio_pkg.sv
// ********************************************************************
// parallel port constants and carriers
// ********************************************************************
package pio_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int P0_W = 8;
    localparam int P1_W = 6;
    localparam int P2_W = 3;
    localparam int PINS_W = P0_W + P1_W + P2_W;

    // register byte addresses
    localparam logic [ADDR_W-1:0] OFS_P0_LATCH = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_P0_PINS = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_P1_LATCH = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_P1_DIR = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_P2_LATCH = 12'h018;
    localparam logic [ADDR_W-1:0] OFS_P2_PINS = 12'h01c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CTRL = 12'h020;
    localparam logic [ADDR_W-1:0] OFS_CLK_MODE = 12'h024;

    // reset values
    localparam logic [P0_W-1:0] RST_P0_LATCH = 8'hff;
    localparam logic [P1_W-1:0] RST_P1_LATCH = 6'h00;
    localparam logic [P1_W-1:0] RST_P1_DIR = 6'h00;
    localparam logic [P2_W-1:0] RST_P2_LATCH = 3'h7;

    // field positions
    localparam int BIT_IRQ0_EN = 0;   // in ext_irq_control
    localparam int BIT_DUAL_CLK = 0;  // in clock mode register
    localparam int BIT_P0_IRQ0 = 0;   // port 0 pin carrying irq zero
    localparam int BIT_P2_EDGE = 0;   // port 2 pin with falling-edge latch
    localparam int BIT_XT_IN = 1;     // port 2 crystal input pin
    localparam int BIT_XT_OUT = 2;    // port 2 crystal output pin

    // pin levels of all three ports, carried together
    typedef struct packed {
        logic [P2_W-1:0] p2;
        logic [P1_W-1:0] p1;
        logic [P0_W-1:0] p0;
    } pio_pins_t;

    // bus slave phases: S1 samples, S2 commits
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_S1,
        ST_S2
    } pio_state_t;
endpackage

// ### hw/pio_sync.sv
`timescale 1ns/10ps
// ********************************************************************
// two-flop synchroniser
// ********************************************************************
module pio_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk_sys,           // system clock
    input wire logic i_sys_rst,           // sync reset, active high
    input wire logic i_ce,                // clock enable
    input wire logic [WIDTH-1:0] i_async, // asynchronous levels
    output logic [WIDTH-1:0] o_sync       // synchronised levels
);
    logic [WIDTH-1:0] meta;

    // first stage is read only by the second stage
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            meta <= '0;
            o_sync <= '0;
        end else if (i_ce) begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule // pio_sync

// ### hw/pio_ports.sv
// Function
// - outputs driven from latches holding written value
// - port reads sample pins in S1
// - port writes update outputs in S2
// - port 0 latch resets to all ones
// - port 0 latch and pin registers separate
// - port 0 pin 0 selectable as irq zero
// - port 1 six bits, per-pin direction bit
// - port 1 direction and latch reset zero
// - latch writable whatever the direction
// - port 1 upper two bits undefined
// - port 1 read mixes pins and latch
// - port 2 three bits, latch resets ones
// - port 2 pins 1,2 crystal in dual mode
// - port 2 pin 0 falling edge sets latch; here only a one-cycle pulse on o_port_two_edge
// - port 2 upper five bits undefined
// - port 2 latch and pin registers separate
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps
module pio_ports (
    input wire logic i_clk_sys,                        // system clock
    input wire logic i_sys_rst,                        // sync reset
    input wire logic i_ce,                             // clock enable
    // apb slave
    input wire logic i_psel,                           // select
    input wire logic i_penable,                        // access phase
    input wire logic i_pwrite,                         // write when high
    input wire logic [pio_pkg::ADDR_W-1:0] i_paddr,    // byte address
    input wire logic [pio_pkg::DATA_W-1:0] i_pwdata,   // write data
    output logic [pio_pkg::DATA_W-1:0] o_prdata,       // read data
    output logic o_pready,                             // transfer done
    output logic o_pslverr,                            // unmapped address
    // port 0
    input wire logic [pio_pkg::P0_W-1:0] i_p0_pin,     // pin levels
    output logic [pio_pkg::P0_W-1:0] o_p0_out,         // driven level
    output logic [pio_pkg::P0_W-1:0] o_p0_oe,          // drive enable
    // port 1
    input wire logic [pio_pkg::P1_W-1:0] i_p1_pin,     // pin levels
    output logic [pio_pkg::P1_W-1:0] o_p1_out,         // driven level
    output logic [pio_pkg::P1_W-1:0] o_p1_oe,          // drive enable
    // port 2
    input wire logic [pio_pkg::P2_W-1:0] i_p2_pin,     // pin levels
    output logic [pio_pkg::P2_W-1:0] o_p2_out,         // driven level
    output logic [pio_pkg::P2_W-1:0] o_p2_oe,          // drive enable
    // alternate functions
    output logic o_ext_irq_zero_input,                 // irq zero level
    output logic o_port_two_edge,                      // pin 0 fall pulse
    output logic o_low_freq_crystal_en                 // crystal pins owned
);
    // ****************************************************************
    // state
    // ****************************************************************
    pio_pkg::pio_state_t state;
    pio_pkg::pio_state_t next_state;
    logic [pio_pkg::P0_W-1:0] port0_output_latch;
    logic [pio_pkg::P1_W-1:0] port1_output_latch;
    logic [pio_pkg::P1_W-1:0] port1_direction;
    logic [pio_pkg::P2_W-1:0] port2_output_latch;
    logic ext_irq_zero_enable;
    logic dual_clock;
    logic p2_edge_prev;
    pio_pkg::pio_pins_t pins_raw;
    pio_pkg::pio_pins_t pins;

    // ****************************************************************
    // pin synchronisation
    // ****************************************************************
    // pins change at any time, so nothing reads them unsynchronised
    assign pins_raw = '{p2: i_p2_pin, p1: i_p1_pin, p0: i_p0_pin};

    pio_sync #(
        .WIDTH(pio_pkg::PINS_W)
    ) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_async(pins_raw),
        .o_sync(pins)
    );

    // ****************************************************************
    // address decode
    // ****************************************************************
    wire logic sel_p0_latch = (i_paddr == pio_pkg::OFS_P0_LATCH);
    wire logic sel_p0_pins = (i_paddr == pio_pkg::OFS_P0_PINS);
    wire logic sel_p1_latch = (i_paddr == pio_pkg::OFS_P1_LATCH);
    wire logic sel_p1_dir = (i_paddr == pio_pkg::OFS_P1_DIR);
    wire logic sel_p2_latch = (i_paddr == pio_pkg::OFS_P2_LATCH);
    wire logic sel_p2_pins = (i_paddr == pio_pkg::OFS_P2_PINS);
    wire logic sel_irq = (i_paddr == pio_pkg::OFS_IRQ_CTRL);
    wire logic sel_mode = (i_paddr == pio_pkg::OFS_CLK_MODE);
    wire logic sel_any = sel_p0_latch | sel_p0_pins | sel_p1_latch |
        sel_p1_dir | sel_p2_latch | sel_p2_pins | sel_irq | sel_mode;

    // the write commits only at the edge that sees pready high
    wire logic commit = (state == pio_pkg::ST_S2) & i_psel & i_penable;
    wire logic wr = commit & i_pwrite;
    wire logic rd_sample = (state == pio_pkg::ST_S1) & ~i_pwrite;

    // ****************************************************************
    // read data mux
    // ****************************************************************
    // input bits show pins, output bits show latch; a bit-set by
    // software therefore copies pin levels into input latches
    wire logic [pio_pkg::P1_W-1:0] p1_view =
        (port1_direction & port1_output_latch) |
        (~port1_direction & pins.p1);

    // unimplemented upper bits read as zero, one allowed value
    logic [pio_pkg::DATA_W-1:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        if (sel_p0_latch) begin
            rd_mux[pio_pkg::P0_W-1:0] = port0_output_latch;
        end else if (sel_p0_pins) begin
            rd_mux[pio_pkg::P0_W-1:0] = pins.p0;
        end else if (sel_p1_latch) begin
            rd_mux[pio_pkg::P1_W-1:0] = p1_view;
        end else if (sel_p1_dir) begin
            rd_mux[pio_pkg::P1_W-1:0] = port1_direction;
        end else if (sel_p2_latch) begin
            rd_mux[pio_pkg::P2_W-1:0] = port2_output_latch;
        end else if (sel_p2_pins) begin
            rd_mux[pio_pkg::P2_W-1:0] = pins.p2;
        end else if (sel_irq) begin
            rd_mux[pio_pkg::BIT_IRQ0_EN] = ext_irq_zero_enable;
        end else if (sel_mode) begin
            rd_mux[pio_pkg::BIT_DUAL_CLK] = dual_clock;
        end
    end

    // ****************************************************************
    // bus phase sequencing
    // ****************************************************************
    // idle -> S1 on first access cycle, S2 answers with pready
    always_comb begin
        next_state = state;
        case (state)
            pio_pkg::ST_IDLE: begin
                if (i_psel & i_penable) begin
                    next_state = pio_pkg::ST_S1;
                end
            end
            pio_pkg::ST_S1: begin
                next_state = pio_pkg::ST_S2;
            end
            pio_pkg::ST_S2: begin
                next_state = pio_pkg::ST_IDLE;
            end
            default: begin
                next_state = pio_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            state <= pio_pkg::ST_IDLE;
        end else if (i_ce) begin
            state <= next_state;
        end
    end

    // bus answer: data is frozen at S1, pready stands one cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_prdata <= '0;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else if (i_ce) begin
            o_pready <= (state == pio_pkg::ST_S1);
            if (state == pio_pkg::ST_S1) begin
                o_pslverr <= ~sel_any;
            end else begin
                o_pslverr <= 1'b0;
            end
            if (rd_sample) begin
                o_prdata <= rd_mux;
            end
        end
    end

    // ****************************************************************
    // latch next values
    // ****************************************************************
    // latches take writes whatever the direction setting
    wire logic [pio_pkg::P0_W-1:0] next_p0_latch = (wr & sel_p0_latch) ?
        i_pwdata[pio_pkg::P0_W-1:0] : port0_output_latch;
    wire logic [pio_pkg::P1_W-1:0] next_p1_latch = (wr & sel_p1_latch) ?
        i_pwdata[pio_pkg::P1_W-1:0] : port1_output_latch;
    wire logic [pio_pkg::P1_W-1:0] next_p1_dir = (wr & sel_p1_dir) ?
        i_pwdata[pio_pkg::P1_W-1:0] : port1_direction;
    wire logic [pio_pkg::P2_W-1:0] next_p2_latch = (wr & sel_p2_latch) ?
        i_pwdata[pio_pkg::P2_W-1:0] : port2_output_latch;
    wire logic next_irq0_en = (wr & sel_irq) ?
        i_pwdata[pio_pkg::BIT_IRQ0_EN] : ext_irq_zero_enable;
    wire logic next_dual = (wr & sel_mode) ?
        i_pwdata[pio_pkg::BIT_DUAL_CLK] : dual_clock;

    // ****************************************************************
    // pin drive enables
    // ****************************************************************
    // port 0: a zero latch pulls low, a one releases for input use;
    // irq zero use releases pin 0 even if software left a zero there
    logic [pio_pkg::P0_W-1:0] next_p0_oe;
    always_comb begin
        next_p0_oe = ~next_p0_latch;
        if (next_irq0_en) begin
            next_p0_oe[pio_pkg::BIT_P0_IRQ0] = 1'b0;
        end
    end

    // port 2: like port 0; crystal pins are released in dual mode
    logic [pio_pkg::P2_W-1:0] next_p2_oe;
    always_comb begin
        next_p2_oe = ~next_p2_latch;
        if (next_dual) begin
            next_p2_oe[pio_pkg::BIT_XT_IN] = 1'b0;
            next_p2_oe[pio_pkg::BIT_XT_OUT] = 1'b0;
        end
    end

    // ****************************************************************
    // port registers
    // ****************************************************************
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            port0_output_latch <= pio_pkg::RST_P0_LATCH;
            port1_output_latch <= pio_pkg::RST_P1_LATCH;
            port1_direction <= pio_pkg::RST_P1_DIR;
            port2_output_latch <= pio_pkg::RST_P2_LATCH;
            ext_irq_zero_enable <= 1'b0;
            dual_clock <= 1'b0;
        end else if (i_ce) begin
            port0_output_latch <= next_p0_latch;
            port1_output_latch <= next_p1_latch;
            port1_direction <= next_p1_dir;
            port2_output_latch <= next_p2_latch;
            ext_irq_zero_enable <= next_irq0_en;
            dual_clock <= next_dual;
        end
    end

    // pin drivers update in the same edge as the latches
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_p0_out <= pio_pkg::RST_P0_LATCH;
            o_p0_oe <= '0;
            o_p1_out <= pio_pkg::RST_P1_LATCH;
            o_p1_oe <= '0;
            o_p2_out <= pio_pkg::RST_P2_LATCH;
            o_p2_oe <= '0;
            o_low_freq_crystal_en <= 1'b0;
        end else if (i_ce) begin
            o_p0_out <= next_p0_latch;
            o_p0_oe <= next_p0_oe;
            o_p1_out <= next_p1_latch;
            o_p1_oe <= next_p1_dir;
            o_p2_out <= next_p2_latch;
            o_p2_oe <= next_p2_oe;
            o_low_freq_crystal_en <= next_dual;
        end
    end

    // ****************************************************************
    // alternate inputs
    // ****************************************************************
    // edge detect looks at the synchronised level, which also shows
    // the pin's own output when driven, so a driven fall is seen too
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            // same level as the synchroniser's reset, so no false
            // fall is seen on the first edges after reset
            p2_edge_prev <= 1'b0;
            o_port_two_edge <= 1'b0;
            o_ext_irq_zero_input <= 1'b0;
        end else if (i_ce) begin
            p2_edge_prev <= pins.p2[pio_pkg::BIT_P2_EDGE];
            o_port_two_edge <= p2_edge_prev &
                ~pins.p2[pio_pkg::BIT_P2_EDGE];
            o_ext_irq_zero_input <= ext_irq_zero_enable &
                pins.p0[pio_pkg::BIT_P0_IRQ0];
        end
    end
endmodule // pio_ports

// ### tb/pio_pins_model.sv
`timescale 1ns/10ps
// ********
// external circuitry on the port pins
// ********
module pio_pins_model (
    input wire logic [pio_pkg::P0_W-1:0] i_p0_out, // port 0 level
    input wire logic [pio_pkg::P0_W-1:0] i_p0_oe,  // port 0 enable
    input wire logic [pio_pkg::P1_W-1:0] i_p1_out, // port 1 level
    input wire logic [pio_pkg::P1_W-1:0] i_p1_oe,  // port 1 enable
    input wire logic [pio_pkg::P2_W-1:0] i_p2_out, // port 2 level
    input wire logic [pio_pkg::P2_W-1:0] i_p2_oe,  // port 2 enable
    input wire pio_pkg::pio_pins_t i_ext,          // source levels
    output pio_pkg::pio_pins_t o_pins              // resolved pins
);
    // driven bits follow the device, released bits the source, which
    // holds its level until the bench changes it
    assign o_pins = {(i_p2_oe & i_p2_out) | (~i_p2_oe & i_ext.p2),
                     (i_p1_oe & i_p1_out) | (~i_p1_oe & i_ext.p1),
                     (i_p0_oe & i_p0_out) | (~i_p0_oe & i_ext.p0)};
endmodule // pio_pins_model

// ### tb/pio_ports_assertions.sv
`timescale 1ns/10ps
// ********
// port checker
// ********
module pio_ports_assertions (
    input wire logic i_clk_sys,                    // clock
    input wire logic i_sys_rst,                    // reset
    input wire logic i_psel,                       // select
    input wire logic i_penable,                    // access
    input wire logic i_pwrite,                     // write
    input wire logic [pio_pkg::P0_W-1:0] i_p0_pin, // port 0 pins
    input wire logic [pio_pkg::P2_W-1:0] i_p2_pin, // port 2 pins
    input wire logic [pio_pkg::DATA_W-1:0] o_prdata, // read data
    input wire logic o_pready,                     // done
    input wire logic o_pslverr,                    // error
    input wire logic [pio_pkg::P0_W-1:0] o_p0_out, // port 0 level
    input wire logic [pio_pkg::P0_W-1:0] o_p0_oe,  // port 0 enable
    input wire logic [pio_pkg::P1_W-1:0] o_p1_out, // port 1 level
    input wire logic [pio_pkg::P1_W-1:0] o_p1_oe,  // port 1 enable
    input wire logic [pio_pkg::P2_W-1:0] o_p2_out, // port 2 level
    input wire logic [pio_pkg::P2_W-1:0] o_p2_oe,  // port 2 enable
    input wire logic o_ext_irq_zero_input,         // irq zero
    input wire logic o_port_two_edge,              // fall pulse
    input wire logic o_low_freq_crystal_en         // crystal mode
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    // access phase start: first cycle with penable high
    sequence s_start;
        i_psel && i_penable && !$past(i_penable);
    endsequence
    // ready is low one cycle, then stands for the next
    sequence s_answer;
        !o_pready ##1 o_pready;
    endsequence
    a_ready_one_wait: assert property (s_start |=> s_answer)
        else $error("ready not one cycle after access");
    a_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    a_err_ready: assert property (o_pslverr |-> o_pready)
        else $error("error without ready");
    a_err_zero: assert property (
        o_pslverr && !i_pwrite |-> o_prdata == 0)
        else $error("refused read data not zero");
    // pins move only one edge after a write or out of reset
    a_out_hold: assert property (
        !$past(o_pready && i_pwrite) && !$past(i_sys_rst)
        |-> $stable({o_p0_out, o_p0_oe, o_p1_out, o_p1_oe, o_p2_out,
        o_p2_oe})) else $error("outputs moved without write");
    a_rst_vals: assert property (
        $fell(i_sys_rst) |-> o_p0_out == 8'hff && o_p0_oe == 0 &&
        o_p1_out == 0 && o_p1_oe == 0 && o_p2_out == 3'h7)
        else $error("bad output reset values");
    // the level register lags the enable by one edge, so the drive
    // enable is looked at one edge back
    a_irq_pin: assert property (o_ext_irq_zero_input |->
        $past(i_p0_pin[0], 3) && !$past(o_p0_oe[0]))
        else $error("irq zero bad");
    // two sync edges, one compare edge, one output edge
    a_edge_cause: assert property (o_port_two_edge |->
        !$past(i_p2_pin[0], 3) && $past(i_p2_pin[0], 4))
        else $error("edge pulse without falling pin");
    a_edge_pulse: assert property (
        o_port_two_edge |=> !o_port_two_edge)
        else $error("edge pulse too long");
    a_xtal_pins: assert property (o_low_freq_crystal_en |->
        o_p2_oe[2:1] == 2'h0) else $error("crystal pins driven");
endmodule // pio_ports_assertions

bind pio_ports pio_ports_assertions u_chk (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_p0_pin(i_p0_pin),
    .i_p2_pin(i_p2_pin), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_p0_out(o_p0_out), .o_p0_oe(o_p0_oe),
    .o_p1_out(o_p1_out), .o_p1_oe(o_p1_oe), .o_p2_out(o_p2_out),
    .o_p2_oe(o_p2_oe), .o_ext_irq_zero_input(o_ext_irq_zero_input),
    .o_port_two_edge(o_port_two_edge),
    .o_low_freq_crystal_en(o_low_freq_crystal_en)
);

// ### tb/pio_ports_tb.sv
`timescale 1ns/10ps
// ********
// port block bench
// ********
module pio_ports_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, v, e;
    logic [31:0] lfsr = 32'h3d5d1338;
    logic pready, pslverr, irq0, edg, xtal;
    logic [7:0] p0_out, p0_oe;
    logic [5:0] p1_out, p1_oe;
    logic [2:0] p2_out, p2_oe;
    pio_pkg::pio_pins_t ext = '0, pins;
    logic [11:0] rst_addr [5] = '{12'h000, 12'h014, 12'h018, 12'h020,
                                  12'h024};
    logic [31:0] rst_val [5] = '{32'hff, 32'h0, 32'h7, 32'h0, 32'h0};
    int n_fail = 0, tests_run = 0, n_edge = 0, n_base = 0;

    // 100 MHz clock and edge pulse counter
    always #5 clk = ~clk;
    always @(posedge clk) if (edg === 1'b1) n_edge <= n_edge + 1;

    pio_ports u_dut (
        .i_clk_sys(clk), .i_sys_rst(rst), .i_ce(1'b1),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr),
        .i_p0_pin(pins.p0), .o_p0_out(p0_out), .o_p0_oe(p0_oe),
        .i_p1_pin(pins.p1), .o_p1_out(p1_out), .o_p1_oe(p1_oe),
        .i_p2_pin(pins.p2), .o_p2_out(p2_out), .o_p2_oe(p2_oe),
        .o_ext_irq_zero_input(irq0), .o_port_two_edge(edg),
        .o_low_freq_crystal_en(xtal)
    );
    pio_pins_model u_pins (
        .i_p0_out(p0_out), .i_p0_oe(p0_oe), .i_p1_out(p1_out),
        .i_p1_oe(p1_oe), .i_p2_out(p2_out), .i_p2_oe(p2_oe),
        .i_ext(ext), .o_pins(pins)
    );

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // inputs read the pins, outputs the latch
    function automatic logic [5:0] exp_p1(input logic [5:0] d, l, x);
        return (d & l) | (~d & x);
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("mismatches %0d checks %0d", n_fail, tests_run);
        if (n_fail == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // one apb transfer; the wait for ready is bounded
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        // ready and data are taken at the rising edge that sees ready
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            n_fail++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
    endtask
    task automatic chk_reset;
        check(32'({p0_out, p0_oe}), 32'hff00);
        check(32'({p1_out, p1_oe, p2_out}), 32'h7);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, rst_addr[i], 32'h0);
            check(rd, rst_val[i]);
        end
    endtask

    // ********
    // main sequence
    // ********
    initial begin
        do_reset();
        chk_reset();
        // random latch, direction and pin mixes, all-zero and all-one first
        for (int i = 0; i < 24; i++) begin
            lfsr = next_rand(lfsr);
            v = (i == 0) ? 32'h0 : (i == 1) ? 32'hffffffff : lfsr;
            e = next_rand(lfsr ^ 32'h5a5a5a5a);
            ext <= e[16:0];
            apb(1'b1, pio_pkg::OFS_P0_LATCH, {24'h0, v[7:0]});
            apb(1'b1, pio_pkg::OFS_P1_LATCH, {26'h0, v[13:8]});
            apb(1'b1, pio_pkg::OFS_P1_DIR, {26'h0, v[19:14]});
            apb(1'b1, pio_pkg::OFS_P2_LATCH, {29'h0, v[22:20]});
            @(negedge clk);
            check(32'({p0_out, p0_oe}), {16'h0, v[7:0], ~v[7:0]});
            check(32'({p1_out, p1_oe, p2_out, p2_oe}),
                  {14'h0, v[13:8], v[19:14], v[22:20], ~v[22:20]});
            apb(1'b0, pio_pkg::OFS_P0_PINS, 32'h0);
            check(rd, {24'h0, v[7:0] & e[7:0]});
            apb(1'b0, pio_pkg::OFS_P1_LATCH, 32'h0);
            check(rd, {26'h0, exp_p1(v[19:14], v[13:8], e[13:8])});
            apb(1'b0, pio_pkg::OFS_P2_PINS, 32'h0);
            check(rd, {29'h0, v[22:20] & e[16:14]});
        end
        // pin register ignores writes, unmapped address is refused
        apb(1'b1, pio_pkg::OFS_P0_PINS, 32'h0);
        apb(1'b0, pio_pkg::OFS_P0_LATCH, 32'h0);
        check(rd, {24'h0, v[7:0]});
        apb(1'b0, 12'h030, 32'h0);
        check({err, rd[30:0]}, 32'h80000000);
        // irq zero takes pin 0 and overrides its drive
        apb(1'b1, pio_pkg::OFS_P0_LATCH, 32'hfe);
        apb(1'b1, pio_pkg::OFS_IRQ_CTRL, 32'h1);
        ext.p0 <= 8'h01;
        repeat (5) @(posedge clk);
        @(negedge clk);
        check({23'h0, irq0, p0_oe}, 32'h100);
        @(posedge clk);
        ext.p0 <= 8'h00;
        repeat (5) @(posedge clk);
        @(negedge clk);
        check(32'(irq0), 32'h0);
        apb(1'b1, pio_pkg::OFS_IRQ_CTRL, 32'h0);
        // falling pin 0 of port 2 by the source, then by the latch
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, pio_pkg::OFS_P2_LATCH, 32'h7);
            ext.p2 <= 3'h1;
            repeat (6) @(posedge clk);
            n_base = n_edge;
            if (i == 0)
                ext.p2 <= 3'h0;
            else
                apb(1'b1, pio_pkg::OFS_P2_LATCH, 32'h6);
            repeat (8) @(posedge clk);
            check(32'(n_edge - n_base), 32'h1);
        end
        // crystal mode releases pins 1 and 2 of port 2
        apb(1'b1, pio_pkg::OFS_CLK_MODE, 32'h1);
        apb(1'b1, pio_pkg::OFS_P2_LATCH, 32'h0);
        @(negedge clk);
        check({28'h0, xtal, p2_oe}, 32'h9);
        apb(1'b1, pio_pkg::OFS_CLK_MODE, 32'h0);
        @(negedge clk);
        check({28'h0, xtal, p2_oe}, 32'h7);
        do_reset();
        chk_reset();
        give_verdict();
    end
endmodule // pio_ports_tb
